// ---- sbs_pkg.sv ----
/*
 * Shared constants, state enum and carrier structs for the synchronous
 * burst memory block. Assumes a single clock domain and a 36-bit word
 * split into four 9-bit byte lanes.
 */
`default_nettype none
package sbs_pkg;
	localparam int ADDR_W = 18; // Word address width
	localparam int HIGH_W = 16; // Address bits above the burst counter
	localparam int DATA_W = 36; // Data word width
	localparam int LANES = 4; // Byte lanes per word
	localparam int LANE_W = 9; // Bits per byte lane
	localparam int FIFO_DEPTH = 4; // Write commit queue depth
	localparam logic [1:0] CNT_RESET = 2'h0; // Burst index after reset
	localparam logic [1:0] CNT_AFTER_LOAD = 2'h1; // Index of second beat
	localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h0; // Address regs after reset
	localparam logic [DATA_W-1:0] DQ_RESET = 36'h0; // Output word after reset
	localparam logic [LANES-1:0] LANES_RESET = 4'hf; // No lane enabled

	// Access kind held for a whole burst
	typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_state_e;

	// One sampled access, address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes_n;
	} sbs_op_s;

	// One write waiting to reach the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes_n;
		logic [DATA_W-1:0] data;
	} sbs_wr_s;
endpackage
`default_nettype wire

// ---- sbs_fifo.sv ----
/*
 * Parameterised first-in first-out queue with valid/ready on both sides.
 * Assumes DEPTH is a power of two and both sides share clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH); // Index width
	logic [WIDTH-1:0] store [0:DEPTH-1]; // Entry storage
	logic [PW:0] wr_ptr; // Write pointer with wrap bit
	logic [PW:0] rd_ptr; // Read pointer with wrap bit
	logic push; // Entry accepted
	logic pop; // Entry removed

	// Full when indices match and wrap bits differ
	assign in_ready = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = store[rd_ptr[PW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer update
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Entry write
	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr[PW-1:0]] <= in_data;
		end
	end
endmodule // sbs_fifo
`default_nettype wire

// ---- sbs_sram_core.sv ----
/*
 * Device-side logic of a synchronous flow-through burst memory with byte
 * writes and a four-word internal burst. Assumes all control, address and
 * data inputs are driven synchronously to clk by the memory controller.
 */
// Notes on behaviour
// - Load low ends burst, starts new access
// - Burst direction fixed at address load
// - Read/write level ignored while bursting
// - Four-word burst, linear or interleaved order
// - Write starts only with load and write low
// - Lane strobes lead their data by one cycle
// - Gated edge changes no internal state
// - Deselect finishes pending transfer, floats bus next
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core
	import sbs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_gate_n,
	input wire logic chip_sel_n,
	input wire logic chip_sel2,
	input wire logic chip_sel2_n,
	input wire logic load_advance_n,
	input wire logic read_write_n,
	input wire logic burst_interleave,
	input wire logic [HIGH_W-1:0] addr_high,
	input wire logic burst_addr_bit1,
	input wire logic burst_addr_bit0,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);
	logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1]; // Storage array
	logic active; // Edge not gated
	logic selected; // All chip selects active
	logic load; // New access sampled
	sbs_state_e state; // Current burst kind
	logic [ADDR_W-1:0] base; // Loaded burst address
	logic [1:0] cnt; // Index of next beat
	sbs_op_s op; // Access in its address phase
	sbs_wr_s wr_data; // Write entering the queue
	logic wr_valid; // Write beat ready to queue
	logic wr_ready; // Queue has room
	sbs_wr_s head; // Oldest queued write
	logic head_valid; // Queue holds an entry
	logic hit; // Queued write matches read word

	// Burst address low bits for a beat index
	function automatic logic [1:0] beat_low(input logic [1:0] start, input logic [1:0] idx,
		input logic inter);
		beat_low = inter ? (start ^ idx) : 2'(start + idx);
	endfunction

	// Overlay enabled lanes of a queued write onto a word
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] word, input sbs_wr_s w);
		merge = word;
		for (int i = 0; i < LANES; i++) begin
			if (!w.lanes_n[i]) begin
				merge[i*LANE_W +: LANE_W] = w.data[i*LANE_W +: LANE_W];
			end
		end
	endfunction

	assign active = !clk_gate_n;
	assign selected = !chip_sel_n && chip_sel2 && !chip_sel2_n;
	assign load = !load_advance_n;

	// Burst kind; read/write level only looked at on load
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= SBS_IDLE;
		end else if (active) begin
			if (load) begin
				if (!selected) begin
					state <= SBS_IDLE;
				end else if (read_write_n) begin
					state <= SBS_READ;
				end else begin
					state <= SBS_WRITE;
				end
			end // Advancing keeps direction
		end
	end

	// Burst base address and two-bit counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			base <= ADDR_RESET;
			cnt <= CNT_RESET;
		end else if (active) begin
			if (load) begin
				base <= {addr_high, burst_addr_bit1, burst_addr_bit0};
				cnt <= CNT_AFTER_LOAD;
			end else if (state != SBS_IDLE) begin
				cnt <= cnt + 2'h1; // Wraps after four beats
			end
		end
	end

	// Address phase register of each beat
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op <= '{valid: 1'b0, write: 1'b0, addr: ADDR_RESET, lanes_n: LANES_RESET};
		end else if (active) begin
			op.lanes_n <= byte_lane_write_n; // Strobes lead data
			if (load) begin
				op.valid <= selected;
				op.write <= !read_write_n;
				op.addr <= {addr_high, burst_addr_bit1, burst_addr_bit0};
			end else begin
				op.valid <= (state != SBS_IDLE);
				op.write <= (state == SBS_WRITE);
				op.addr <= {base[ADDR_W-1:2], beat_low(base[1:0], cnt, burst_interleave)};
			end
		end
	end

	// Write beat joins its strobes from the previous edge
	assign wr_valid = active && op.valid && op.write;
	assign wr_data = '{addr: op.addr, lanes_n: op.lanes_n, data: dq_in};

	sbs_fifo #(
		.WIDTH($bits(sbs_wr_s)),
		.DEPTH(FIFO_DEPTH)
	) u_wr_queue (
		.clk(clk),
		.reset(reset),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(head_valid),
		.out_ready(active),
		.out_data(head)
	);

	// Drain queue into array on ungated edges
	always_ff @(posedge clk) begin
		if (head_valid && active) begin
			for (int i = 0; i < LANES; i++) begin
				if (!head.lanes_n[i]) begin
					mem[head.addr][i*LANE_W +: LANE_W] <= head.data[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Forward a write still in the queue
	assign hit = head_valid && (head.addr == op.addr);

	// Data phase: drive read word, float otherwise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dq_out <= DQ_RESET;
			dq_oe <= 1'b0;
		end else if (active) begin
			if (op.valid && !op.write) begin
				dq_out <= hit ? merge(mem[op.addr], head) : mem[op.addr];
				dq_oe <= 1'b1;
			end else begin // Write or deselect floats bus
				dq_oe <= 1'b0;
			end
		end
	end

	// Checks
	load_start_a: assert property (@(posedge clk) disable iff (reset)
		active && load && selected |=> op.valid && op.addr == $past({addr_high, burst_addr_bit1, burst_addr_bit0}))
		else $error("load did not start a new access");
	dir_fixed_a: assert property (@(posedge clk) disable iff (reset)
		active && load && selected |=> state == ($past(read_write_n) ? SBS_READ : SBS_WRITE))
		else $error("burst direction not taken at load");
	rw_ignored_a: assert property (@(posedge clk) disable iff (reset)
		active && !load |=> state == $past(state) && op.write == ($past(state) == SBS_WRITE))
		else $error("direction changed during burst");
	burst_order_a: assert property (@(posedge clk) disable iff (reset)
		active && load && selected ##1 (active && !load) [*3] |=>
		op.addr[1:0] == beat_low($past(base[1:0], 1), 2'h3, $past(burst_interleave, 1)))
		else $error("fourth burst beat at wrong address");
	write_start_a: assert property (@(posedge clk) disable iff (reset)
		state == SBS_WRITE && $past(state) != SBS_WRITE |-> $past(load && !read_write_n && active))
		else $error("write began without load and write low");
	lane_pair_a: assert property (@(posedge clk) disable iff (reset)
		wr_valid && $past(active) |-> wr_data.lanes_n == $past(byte_lane_write_n) && wr_data.data == dq_in)
		else $error("strobes not paired with next data");
	gate_hold_a: assert property (@(posedge clk) disable iff (reset)
		!active |=> $stable(state) && $stable(cnt) && $stable(op) && $stable(dq_oe) && $stable(dq_out))
		else $error("state moved on a gated edge");
	deselect_float_a: assert property (@(posedge clk) disable iff (reset)
		(active && load && !selected) ##1 active |=> !dq_oe)
		else $error("bus not floated after deselect");
	read_latency_a: assert property (@(posedge clk) disable iff (reset)
		active && op.valid && !op.write |=> dq_oe && dq_out == $past(hit ? merge(mem[op.addr], head) : mem[op.addr]))
		else $error("read data not driven one cycle later");
	queue_room_a: assert property (@(posedge clk) disable iff (reset)
		wr_valid |-> wr_ready)
		else $error("write beat met a full queue");
	cnt_load_a: assert property (@(posedge clk) disable iff (reset)
		active && load |=> cnt == CNT_AFTER_LOAD)
		else $error("burst counter not restarted by load");
	write_float_a: assert property (@(posedge clk) disable iff (reset)
		active && op.valid && op.write |=> !dq_oe)
		else $error("bus driven in a write data phase");

	// Cover points for the main scenarios
	read_burst_c: cover property (@(posedge clk) disable iff (reset)
		active && load && selected && read_write_n ##1 (active && !load) [*3] ##1 dq_oe);
	write_then_read_c: cover property (@(posedge clk) disable iff (reset)
		active && load && selected && !read_write_n ##1 active && load && selected && read_write_n ##1 hit);
	gated_edge_c: cover property (@(posedge clk) disable iff (reset)
		state != SBS_IDLE && !active);
	deselect_c: cover property (@(posedge clk) disable iff (reset)
		dq_oe ##1 active && load && !selected ##1 active ##1 !dq_oe);
	// Counter wraps past the fourth beat
	wrap_burst_c: cover property (@(posedge clk) disable iff (reset)
		active && load && selected ##1 (active && !load) [*4]);
endmodule // sbs_sram_core
`default_nettype wire

// ---- sbs_ctrl_model.sv ----
/* Memory controller model that drives the burst memory pins.
   Assumes the bench calls drive once per clock cycle. */
`timescale 1ns/1ps
`default_nettype none
module sbs_ctrl_model
	import sbs_pkg::*;
(
	input wire logic clk,
	output logic clk_gate_n,
	output logic chip_sel_n,
	output logic chip_sel2,
	output logic chip_sel2_n,
	output logic load_advance_n,
	output logic read_write_n,
	output logic burst_interleave,
	output logic [ADDR_W-1:0] addr,
	output logic [LANES-1:0] byte_lane_write_n,
	output logic [DATA_W-1:0] dq_in
);
	// Selected and idle before the first drive
	initial begin
		{clk_gate_n, chip_sel_n, chip_sel2, chip_sel2_n, load_advance_n, read_write_n, burst_interleave} = 7'h16;
		addr = '0;
		byte_lane_write_n = LANES_RESET;
		dq_in = '0;
	end

	// One pin update just after a rising edge; select code 3 keeps all active
	task automatic drive(input logic g, input logic [1:0] s, input logic ld, input logic rw, input logic il,
			input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d);
		@(posedge clk);
		clk_gate_n <= g;
		chip_sel_n <= (s == 2'h0);
		chip_sel2 <= (s != 2'h1);
		chip_sel2_n <= (s == 2'h2);
		load_advance_n <= ld;
		read_write_n <= rw;
		burst_interleave <= il;
		addr <= a;
		byte_lane_write_n <= ln;
		dq_in <= d;
	endtask
endmodule // sbs_ctrl_model
`default_nettype wire

// ---- tb_sync_burst_sram_access.sv ----
/* Self-checking bench: the controller model drives the core and a queue
   model predicts each output word. Assumes one 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_access
	import sbs_pkg::*;
;
	logic clk = 1'b0; // 100 MHz clock
	logic reset = 1'b1; // Held for two cycles
	logic g, cs_n, cs2, cs2_n, ld_n, rw_n, il; // Controller pins
	logic [ADDR_W-1:0] a;
	logic [LANES-1:0] ln;
	logic [DATA_W-1:0] din, dq_out;
	logic dq_oe;
	int errors = 0;
	int n_checks = 0;
	logic [DATA_W-1:0] mem [int]; // Reference array
	logic qoe [$]; // Data phases waiting for a live edge
	logic [DATA_W-1:0] qd [$]; // Words waiting for a live edge
	logic x_oe = 1'b0; // Expected enable after the last edge
	logic [DATA_W-1:0] x_dq = '0; // Expected word after the last edge
	int st = 0; // 0 idle, 1 read, 2 write
	logic [ADDR_W-1:0] base;
	logic [1:0] idx;
	bit pend = 0; // Write beat waiting for its data
	int pa;
	logic [LANES-1:0] pl;

	// Clock
	always #5 clk = ~clk;

	sbs_ctrl_model u_ctrl(.clk(clk), .clk_gate_n(g), .chip_sel_n(cs_n), .chip_sel2(cs2), .chip_sel2_n(cs2_n),
		.load_advance_n(ld_n), .read_write_n(rw_n), .burst_interleave(il), .addr(a),
		.byte_lane_write_n(ln), .dq_in(din));
	sbs_sram_core u_dut(.clk(clk), .reset(reset), .clk_gate_n(g), .chip_sel_n(cs_n), .chip_sel2(cs2),
		.chip_sel2_n(cs2_n), .load_advance_n(ld_n), .read_write_n(rw_n), .burst_interleave(il),
		.addr_high(a[ADDR_W-1:2]), .burst_addr_bit1(a[1]), .burst_addr_bit0(a[0]),
		.byte_lane_write_n(ln), .dq_in(din), .dq_out(dq_out), .dq_oe(dq_oe));

	// Compare and count
	task automatic check(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] v);
		n_checks++;
		if (e !== v) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, v);
		end
	endtask

	// Verdict and end of run
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One cycle: drive, check what the last edge left, then advance the model by these pins
	task automatic step(input logic gt, input logic [1:0] s, input logic l, input logic r, input logic i,
			input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
		logic [1:0] o;
		u_ctrl.drive(gt, s, l, r, i, ad, m, d);
		#1;
		check("dq_oe", DATA_W'(x_oe), DATA_W'(dq_oe));
		if (x_oe)
			check("dq_out", x_dq, dq_out);
		if (!gt) begin // Gated edge changes nothing
			if (pend) begin // Data lands one edge after its strobes
				for (int k = 0; k < LANES; k++)
					if (!pl[k])
						mem[pa][k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
				pend = 0;
			end
			if (!l) begin // Load ends any burst
				st = (s != 2'h3) ? 0 : (r ? 1 : 2);
				base = ad;
				idx = 2'h0;
			end else if (st != 0)
				idx++; // Direction level not looked at
			o = i ? (base[1:0] ^ idx) : (base[1:0] + idx);
			pa = {base[ADDR_W-1:2], o};
			pl = m;
			pend = (st == 2);
			qoe.push_back(st == 1);
			qd.push_back(st == 1 ? mem[pa] : '0);
			if (qoe.size() == 2) begin // Edge taking these pins shows the previous beat
				x_oe = qoe.pop_front();
				x_dq = qd.pop_front();
			end
		end
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h5405c964));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Eight blocks, every start offset in both orders: write all, then read back
		for (int p = 0; p < 2; p++)
			for (int n = 0; n < 8; n++)
				for (int b = 0; b < 4; b++)
					step(1'b0, 2'h3, b != 0, (b != 0) ? 1'($urandom) : p[0], n[2],
						(b != 0) ? ADDR_W'($urandom) : {13'h0, n[2:0], n[1:0]},
						(p == 0) ? 4'h0 : 4'($urandom), DATA_W'({$urandom, $urandom}));
		$display("test burst_sweep done");
		// Gating, deselects, partial lanes and wrapping bursts at random
		repeat (400)
			step($urandom_range(0, 7) == 0, ($urandom_range(0, 5) == 0) ? 2'($urandom_range(0, 2)) : 2'h3,
				$urandom_range(0, 3) != 0, 1'($urandom), 1'($urandom), {13'h0, 3'($urandom), 2'($urandom)},
				4'($urandom), DATA_W'({$urandom, $urandom}));
		repeat (2)
			step(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, '0, 4'hf, '0);
		$display("test random_mix done");
		end_of_test();
	end

	// Watchdog
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
endmodule // tb_sync_burst_sram_access
`default_nettype wire
